// >>> shared/pmx_pkg.sv
package pmx_pkg;
    // Port slots used by every per-port array and by the register map.
    localparam int NPORT = 7;
    localparam int IX_P0 = 0;
    localparam int IX_P1 = 1;
    localparam int IX_P3 = 2;
    localparam int IX_P4 = 3;
    localparam int IX_P5 = 4;
    localparam int IX_P6 = 5;
    localparam int IX_DL = 6;
    // Register kinds in one port block; the kind is the word index.
    localparam logic [2:0] K_LATCH  = 3'h0;
    localparam logic [2:0] K_DIR    = 3'h1;
    localparam logic [2:0] K_MODE   = 3'h2;
    localparam logic [2:0] K_CHOICE = 3'h3;
    localparam logic [2:0] K_OTYPE  = 3'h4;
    localparam logic [2:0] K_PIN    = 3'h5;
    localparam int         NKIND    = 5;
    // Port blocks sit at 0x000 + port*0x20 + kind*4.
    localparam logic [3:0] A_PORT_HI = 4'h0;
    // Global block sits at 0x100; the selector is address bits 3:2.
    localparam logic [7:0] A_GLOB_HI = 8'h10;
    localparam logic [1:0] G_KR_EN   = 2'h0;
    localparam logic [1:0] G_RISE    = 2'h1;
    localparam logic [1:0] G_FALL    = 2'h2;
    localparam logic [1:0] G_STATUS  = 2'h3;
    // Values after reset: all pins inputs, every other bit clear.
    localparam logic [15:0] RST_DIR = 16'hFFFF;
    localparam logic [15:0] RST_CFG = 16'h0000;
    // Key return lines on port 5 and interrupt pins on port 0.
    localparam int        KR_W       = 6;
    localparam logic [5:0] KR_PP_MASK = 6'h30;
    localparam int        IRQ_LO     = 2;
    localparam int        IRQ_W      = 5;
    // Pins without a mode bit (the two analog outputs of port 1).
    localparam logic [6:0][15:0] NOMODE_MASK = {16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0003, 16'h0000};
    // Pins with two alternates, picked by the choice bit.
    localparam logic [6:0][15:0] CHOICE_MASK = {16'h0000, 16'h2000, 16'h003F,
        16'h0000, 16'h0028, 16'h0000, 16'h0000};
    // Pins whose first alternate honours the output type (two-wire bus).
    localparam logic [6:0][15:0] OD_ALT0_MASK = {16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0300, 16'h0000, 16'h0000};
    // Pins whose second alternate honours the output type (realtime bits).
    localparam logic [6:0][15:0] OD_ALT1_MASK = {16'h0000, 16'h0000, 16'h0030,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // Two-wire pins on port 3, absent on variants without that bus.
    localparam logic [15:0] TWOWIRE_MASK = 16'h0300;
    // Drive toward the pads of one port.
    typedef struct packed {
        logic [15:0] o;
        logic [15:0] oe;
    } pin_drive_s;
    // Drive from the peripherals of one port, per alternate.
    typedef struct packed {
        logic [15:0] d0;
        logic [15:0] e0;
        logic [15:0] d1;
        logic [15:0] e1;
    } alt_drive_s;
    // Register bus answer sequence.
    typedef enum logic {APB_IDLE, APB_ANSWER} apb_state_e;
endpackage : pmx_pkg

// >>> rtl/pin_route_cell.sv
`timescale 1ns/1ns
// One pin: picks port latch or a peripheral and applies the output type.
module pin_route_cell #(
    parameter bit HAS_CHOICE = 1'b0,
    parameter bit OD_ALT0    = 1'b0,
    parameter bit OD_ALT1    = 1'b0
) (
    input  wire logic mode,
    input  wire logic choice,
    input  wire logic dir,
    input  wire logic otype,
    input  wire logic latch,
    input  wire logic d0,
    input  wire logic e0,
    input  wire logic d1,
    input  wire logic e1,
    input  wire logic pin,
    output logic      pin_o,
    output logic      pin_oe,
    output logic      alt_i
);
    logic sel1; // Second alternate in use.
    logic od;   // Output acts as open drain.
    logic d;    // Chosen data.
    logic e;    // Chosen enable.

    // Route the pin; open drain only pulls low, so it never drives a one.
    always_comb begin
        sel1 = HAS_CHOICE & choice;
        if (mode) begin
            // Latch and direction play no part here. [R01] [R12]
            d  = sel1 ? d1 : d0; // [R02] [R03] [R11]
            e  = sel1 ? e1 : e0;
            od = otype & (sel1 ? OD_ALT1 : OD_ALT0); // [R05] [R06] [R07] [R08]
        end else begin
            // Plain port: an output drives the latch. [R13]
            d  = latch;
            e  = ~dir;
            od = otype;
        end
        pin_o  = od ? 1'b0 : d;
        pin_oe = od ? (e & ~d) : e;
        // Peripherals see the pin only while they own it.
        alt_i  = mode & pin;
    end
endmodule : pin_route_cell

// >>> rtl/edge_pulse.sv
`timescale 1ns/1ns
// Registered edge detector with per-bit rising and falling enables.
module edge_pulse #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] sig,
    input  wire logic [W-1:0] gate,
    input  wire logic [W-1:0] rise_en,
    input  wire logic [W-1:0] fall_en,
    output logic      [W-1:0] pulse
);
    logic [W-1:0] prev_ff;   // Level seen one cycle ago.
    logic [W-1:0] pulse_ff;  // Registered event.
    logic [W-1:0] nxt_pulse; // Event found this cycle.

    // The previous level tracks even while gated, so opening the gate
    // on a steady pin raises no false edge.
    always_comb begin
        nxt_pulse = gate & ((sig & ~prev_ff & rise_en) | (~sig & prev_ff & fall_en));
    end

    // Register the level and the event.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff  <= {W{1'b0}};
            pulse_ff <= {W{1'b0}};
        end else begin
            prev_ff  <= sig;
            pulse_ff <= nxt_pulse;
        end
    end

    assign pulse = pulse_ff;
endmodule : edge_pulse

// >>> rtl/port_alt_mux.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// R01 - Mode bit set hands pin to peripheral.
// R02 - Port 3 choice: capture input or timer out.
// R03 - Port 5 choice: primary function or realtime bit.
// R04 - Key return needs mode 0, choice 0, input, enabled.
// R05 - Serial pins: key return, realtime need push-pull.
// R06 - Auto-transfer serial ignores output type.
// R07 - Serial channels 0, 2 ignore output type.
// R08 - Two-wire pins need mode 1, open drain.
// R09 - Interrupt pins need mode 1, edge enables.
// R10 - Analog outputs: software sets port 1 inputs.
// R11 - Port 6 top timer choice; realtime mode only.
// R12 - Bus port mode bit picks address/data bus.
// R13 - Mode 0 pin is a plain port.
module port_alt_mux #(
    parameter bit TWOWIRE_PRESENT = 1'b1
) (
    input  wire logic                        CLK,
    input  wire logic                        RSTN,
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [11:0]                 PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    input  wire logic [6:0][15:0]            PIN_IN,
    output pmx_pkg::pin_drive_s [6:0]        PIN_DRV,
    input  wire pmx_pkg::alt_drive_s [6:0]   ALT_DRV,
    output logic      [6:0][15:0]            ALT_IN,
    output logic      [5:0]                  KEY_RETURN,
    output logic      [4:0]                  EDGE_IRQ
);
    // Stored port registers, indexed by port then kind.
    logic [6:0][4:0][15:0] cfg_ff;
    logic [6:0][4:0][15:0] nxt_cfg;
    // Key return enables for port 5 pins 0 to 5.
    logic [5:0]            kr_en_ff;
    logic [5:0]            nxt_kr_en;
    // Edge enables for port 0 pins 2 to 6.
    logic [4:0]            rise_ff;
    logic [4:0]            nxt_rise;
    logic [4:0]            fall_ff;
    logic [4:0]            nxt_fall;
    // Bus answer state and next answer.
    pmx_pkg::apb_state_e   st_ff;
    pmx_pkg::apb_state_e   nxt_st;
    logic                  nxt_ready;
    logic                  nxt_err;
    logic [31:0]           nxt_rdata;
    // Address decode.
    logic [2:0]            a_port;
    logic [2:0]            a_kind;
    logic                  in_port;
    logic                  in_glob;
    logic                  hit;
    logic                  wr_go;
    logic [31:0]           rd;
    // Views of the stored bits; only the mode view gets capability masking.
    logic [6:0][15:0]      latch_w;
    logic [6:0][15:0]      dir_w;
    logic [6:0][15:0]      mode_w;
    logic [6:0][15:0]      choice_w;
    logic [6:0][15:0]      ot_w;
    // Per-pin cell results.
    logic [6:0][15:0]      c_o;
    logic [6:0][15:0]      c_oe;
    logic [6:0][15:0]      c_ai;
    // Next values of the registered outputs.
    pmx_pkg::pin_drive_s [6:0] nxt_drv;
    logic [5:0]            kr_on;
    logic [5:0]            nxt_kr;

    // Split the stored words into fields and mask missing mode bits.
    always_comb begin
        for (int p = 0; p < pmx_pkg::NPORT; p++) begin
            latch_w[p]  = cfg_ff[p][pmx_pkg::K_LATCH];
            dir_w[p]    = cfg_ff[p][pmx_pkg::K_DIR];
            choice_w[p] = cfg_ff[p][pmx_pkg::K_CHOICE];
            ot_w[p]     = cfg_ff[p][pmx_pkg::K_OTYPE];
            // Analog outputs have no mode bit; they count on software
            // making all of port 1 inputs in one write. [R10]
            mode_w[p]   = cfg_ff[p][pmx_pkg::K_MODE] & ~pmx_pkg::NOMODE_MASK[p];
        end
        // Without the two-wire bus those pins stay plain ports. [R08]
        if (!TWOWIRE_PRESENT) begin
            mode_w[pmx_pkg::IX_P3] = mode_w[pmx_pkg::IX_P3] & ~pmx_pkg::TWOWIRE_MASK;
        end
    end

    // One routing cell per pin; capability comes from the package masks.
    for (genvar p = 0; p < pmx_pkg::NPORT; p++) begin : g_port
        for (genvar b = 0; b < 16; b++) begin : g_bit
            pin_route_cell #(
                .HAS_CHOICE (pmx_pkg::CHOICE_MASK[p][b]),
                .OD_ALT0    (pmx_pkg::OD_ALT0_MASK[p][b]),
                .OD_ALT1    (pmx_pkg::OD_ALT1_MASK[p][b])
            ) u_cell (
                .mode   (mode_w[p][b]),
                .choice (choice_w[p][b]),
                .dir    (dir_w[p][b]),
                .otype  (ot_w[p][b]),
                .latch  (latch_w[p][b]),
                .d0     (ALT_DRV[p].d0[b]),
                .e0     (ALT_DRV[p].e0[b]),
                .d1     (ALT_DRV[p].d1[b]),
                .e1     (ALT_DRV[p].e1[b]),
                .pin    (PIN_IN[p][b]),
                .pin_o  (c_o[p][b]),
                .pin_oe (c_oe[p][b]),
                .alt_i  (c_ai[p][b])
            );
        end
    end

    // Key return passes the pin only in the one legal setting.
    always_comb begin
        for (int i = 0; i < pmx_pkg::KR_W; i++) begin
            kr_on[i] = !mode_w[pmx_pkg::IX_P5][i] && !choice_w[pmx_pkg::IX_P5][i]
                && dir_w[pmx_pkg::IX_P5][i] && kr_en_ff[i]; // [R04]
            // The serial output pins also need push-pull type. [R05]
            if (pmx_pkg::KR_PP_MASK[i] && ot_w[pmx_pkg::IX_P5][i]) begin
                kr_on[i] = 1'b0;
            end
        end
        nxt_kr = kr_on & PIN_IN[pmx_pkg::IX_P5][5:0];
    end

    // Gather the pad drive; outputs lag the settings by one cycle.
    always_comb begin
        for (int p = 0; p < pmx_pkg::NPORT; p++) begin
            nxt_drv[p].o  = c_o[p];
            nxt_drv[p].oe = c_oe[p];
        end
    end

    // Register every pad, peripheral and key return output.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            PIN_DRV    <= {7{32'h0000_0000}};
            ALT_IN     <= {7{16'h0000}};
            KEY_RETURN <= 6'h00;
        end else begin
            PIN_DRV    <= nxt_drv;
            ALT_IN     <= c_ai;
            KEY_RETURN <= nxt_kr;
        end
    end

    // Interrupt pins raise events only in alternate mode. [R09]
    edge_pulse #(
        .W (pmx_pkg::IRQ_W)
    ) u_edge (
        .clk     (CLK),
        .rst_n   (RSTN),
        .sig     (PIN_IN[pmx_pkg::IX_P0][pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W]),
        .gate    (mode_w[pmx_pkg::IX_P0][pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W]),
        .rise_en (rise_ff),
        .fall_en (fall_ff),
        .pulse   (EDGE_IRQ)
    );

    // Decode the bus address and build the read word.
    always_comb begin
        a_port  = PADDR[7:5];
        a_kind  = PADDR[4:2];
        in_port = (PADDR[11:8] == pmx_pkg::A_PORT_HI) && (a_port < pmx_pkg::NPORT)
            && (a_kind <= pmx_pkg::K_PIN);
        in_glob = PADDR[11:4] == pmx_pkg::A_GLOB_HI;
        hit     = in_port || in_glob;
        rd      = 32'h0000_0000;
        if (in_port) begin
            // The pin word shows live pad levels, not stored state.
            if (a_kind == pmx_pkg::K_PIN) begin
                rd[15:0] = PIN_IN[a_port];
            end else begin
                rd[15:0] = cfg_ff[a_port][a_kind];
            end
        end else if (in_glob) begin
            case (PADDR[3:2])
                pmx_pkg::G_KR_EN: begin
                    rd[5:0] = kr_en_ff;
                end
                pmx_pkg::G_RISE: begin
                    rd[pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W] = rise_ff;
                end
                pmx_pkg::G_FALL: begin
                    rd[pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W] = fall_ff;
                end
                default: begin
                    rd[5:0] = KEY_RETURN;
                end
            endcase
        end
    end

    // Answer every transfer one cycle after its setup cycle.
    always_comb begin
        nxt_st    = st_ff;
        nxt_ready = 1'b0;
        nxt_rdata = PRDATA;
        nxt_err   = PSLVERR;
        wr_go     = 1'b0;
        case (st_ff)
            pmx_pkg::APB_IDLE: begin
                if (PSEL && !PENABLE) begin
                    nxt_st    = pmx_pkg::APB_ANSWER;
                    nxt_ready = 1'b1;
                    nxt_rdata = PWRITE ? 32'h0000_0000 : rd;
                    nxt_err   = !hit;
                end
            end
            pmx_pkg::APB_ANSWER: begin
                // A write lands at the edge that sees ready high.
                nxt_st = pmx_pkg::APB_IDLE;
                wr_go  = PSEL && PENABLE && PWRITE && hit;
            end
            default: begin
                nxt_st = pmx_pkg::APB_IDLE;
            end
        endcase
    end

    // Register the bus answer.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_ff   <= pmx_pkg::APB_IDLE;
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            PREADY  <= nxt_ready;
            PRDATA  <= nxt_rdata;
            PSLVERR <= nxt_err;
        end
    end

    // Apply register writes; the pin word is read only and ignores them.
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_kr_en = kr_en_ff;
        nxt_rise  = rise_ff;
        nxt_fall  = fall_ff;
        if (wr_go && in_port && a_kind != pmx_pkg::K_PIN) begin
            nxt_cfg[a_port][a_kind] = PWDATA[15:0];
        end
        if (wr_go && in_glob) begin
            case (PADDR[3:2])
                pmx_pkg::G_KR_EN: begin
                    nxt_kr_en = PWDATA[5:0];
                end
                pmx_pkg::G_RISE: begin
                    nxt_rise = PWDATA[pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W];
                end
                pmx_pkg::G_FALL: begin
                    nxt_fall = PWDATA[pmx_pkg::IRQ_LO +: pmx_pkg::IRQ_W];
                end
                default: begin
                    nxt_kr_en = kr_en_ff;
                end
            endcase
        end
    end

    // Register the settings; pins start as inputs so nothing is driven.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int p = 0; p < pmx_pkg::NPORT; p++) begin
                for (int k = 0; k < pmx_pkg::NKIND; k++) begin
                    cfg_ff[p][k] <= pmx_pkg::RST_CFG;
                end
                cfg_ff[p][pmx_pkg::K_DIR] <= pmx_pkg::RST_DIR;
            end
            kr_en_ff <= 6'h00;
            rise_ff  <= 5'h00;
            fall_ff  <= 5'h00;
        end else begin
            cfg_ff   <= nxt_cfg;
            kr_en_ff <= nxt_kr_en;
            rise_ff  <= nxt_rise;
            fall_ff  <= nxt_fall;
        end
    end

    // Checks on the routing, all sampled on the one clock.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // A realtime pin has no choice bit, so alternate 0 must win whatever it holds.
    alt_owns_pin_a: assert property (mode_w[pmx_pkg::IX_P6][0] |=> // [R01]
        PIN_DRV[pmx_pkg::IX_P6].o[0] == $past(ALT_DRV[pmx_pkg::IX_P6].d0[0])
        && PIN_DRV[pmx_pkg::IX_P6].oe[0] == $past(ALT_DRV[pmx_pkg::IX_P6].e0[0]))
        else $error("Alternate mode did not pass the peripheral drive.");

    p3_timer_out_a: assert property ( // [R02]
        mode_w[pmx_pkg::IX_P3][3] && choice_w[pmx_pkg::IX_P3][3] |=>
        PIN_DRV[pmx_pkg::IX_P3].o[3] == $past(ALT_DRV[pmx_pkg::IX_P3].d1[3]))
        else $error("Port 3 timer output not selected.");

    p5_primary_a: assert property ( // [R03]
        mode_w[pmx_pkg::IX_P5][4] && !choice_w[pmx_pkg::IX_P5][4] |=>
        PIN_DRV[pmx_pkg::IX_P5].o[4] == $past(ALT_DRV[pmx_pkg::IX_P5].d0[4]))
        else $error("Port 5 primary function not selected.");

    key_gate_a: assert property (KEY_RETURN[0] |-> // [R04]
        $past(!mode_w[pmx_pkg::IX_P5][0] && !choice_w[pmx_pkg::IX_P5][0]
        && dir_w[pmx_pkg::IX_P5][0] && kr_en_ff[0]))
        else $error("Key return passed outside its setting.");

    kr_pushpull_a: assert property (ot_w[pmx_pkg::IX_P5][4] |=> !KEY_RETURN[4]) // [R05]
        else $error("Key return passed with open drain type.");

    autoxfer_type_a: assert property ( // [R06]
        mode_w[pmx_pkg::IX_P5][4] && !choice_w[pmx_pkg::IX_P5][4] |=>
        PIN_DRV[pmx_pkg::IX_P5].oe[4] == $past(ALT_DRV[pmx_pkg::IX_P5].e0[4]))
        else $error("Output type altered the auto-transfer output.");

    serial_type_a: assert property (mode_w[pmx_pkg::IX_P4][1] |=> // [R07]
        PIN_DRV[pmx_pkg::IX_P4].o[1] == $past(ALT_DRV[pmx_pkg::IX_P4].d0[1]))
        else $error("Output type altered a serial output.");

    twowire_od_a: assert property ( // [R08]
        mode_w[pmx_pkg::IX_P3][8] && ot_w[pmx_pkg::IX_P3][8] |=>
        !PIN_DRV[pmx_pkg::IX_P3].o[8] && PIN_DRV[pmx_pkg::IX_P3].oe[8] ==
        $past(ALT_DRV[pmx_pkg::IX_P3].e0[8] && !ALT_DRV[pmx_pkg::IX_P3].d0[8]))
        else $error("Two-wire pin not open drain.");

    irq_rise_a: assert property ( // [R09]
        mode_w[pmx_pkg::IX_P0][3] && rise_ff[1] && !PIN_IN[pmx_pkg::IX_P0][3] ##1
        mode_w[pmx_pkg::IX_P0][3] && rise_ff[1] && PIN_IN[pmx_pkg::IX_P0][3]
        |=> EDGE_IRQ[1])
        else $error("Rising edge on interrupt pin was missed.");

    p6_timer_a: assert property ( // [R11]
        mode_w[pmx_pkg::IX_P6][13] && choice_w[pmx_pkg::IX_P6][13] |=>
        PIN_DRV[pmx_pkg::IX_P6].o[13] == $past(ALT_DRV[pmx_pkg::IX_P6].d1[13]))
        else $error("Port 6 timer output not selected.");

    bus_port_a: assert property (mode_w[pmx_pkg::IX_DL][0] |=> // [R12]
        PIN_DRV[pmx_pkg::IX_DL].oe[0] == $past(ALT_DRV[pmx_pkg::IX_DL].e0[0]))
        else $error("Bus port pin not handed to the bus.");

    plain_port_a: assert property ( // [R13]
        !mode_w[pmx_pkg::IX_DL][0] && !dir_w[pmx_pkg::IX_DL][0]
        && !ot_w[pmx_pkg::IX_DL][0] |=> PIN_DRV[pmx_pkg::IX_DL].oe[0]
        && PIN_DRV[pmx_pkg::IX_DL].o[0] == $past(latch_w[pmx_pkg::IX_DL][0]))
        else $error("Plain output pin not driving its latch.");
endmodule : port_alt_mux

// >>> bench/pad_model.sv
`timescale 1ns/1ns
// Far side of the pads: a driven pin shows its drive, a released pin the outside level.
module pad_model (
    input  wire pmx_pkg::pin_drive_s [6:0] drv,
    input  wire logic [6:0][15:0]          ext,
    output logic      [6:0][15:0]          pad
);
    // Pull-ups sit behind ext, so a released pin never keeps the last driven value.
    always_comb begin
        for (int p = 0; p < 7; p++) begin
            pad[p] = (drv[p].oe & drv[p].o) | (~drv[p].oe & ext[p]);
        end
    end
endmodule : pad_model

// >>> bench/port_alt_mux_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the pin multiplexer, configured over APB.
module port_alt_mux_tb;
    logic                      clk = 1'b0;            // System clock.
    logic                      rstn = 1'b0;           // Active-low reset.
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [11:0]               paddr = 12'h000;
    logic [31:0]               pwdata = 32'h0000_0000;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [6:0][15:0]          pad;                   // Resolved pad levels.
    logic [6:0][15:0]          ext = '1;              // Outside levels, pulled high.
    pmx_pkg::pin_drive_s [6:0] drv;
    pmx_pkg::alt_drive_s [6:0] alt = '0;              // Peripheral drive.
    logic [6:0][15:0]          alt_in;
    logic [5:0]                kr;
    logic [4:0]                irq;
    int                        mismatches = 0;
    int                        checked = 0;
    logic [31:0]               rd;                    // Last read data.
    logic                      err;                   // Last error answer.
    logic                      seen;                  // Edge pulse observed.
    // Rows: slot, pin, mode choice dir otype latch d0 e0 d1 e1, then o oe alt_in.
    logic [18:0]               rows [16];

    // A half period of 2 ns gives 250 MHz.
    always #2 clk = ~clk;

    port_alt_mux uut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pad), .PIN_DRV(drv),
        .ALT_DRV(alt), .ALT_IN(alt_in), .KEY_RETURN(kr), .EDGE_IRQ(irq));
    pad_model far (.drv(drv), .ext(ext), .pad(pad));

    // Byte address of one register kind in a port block.
    function automatic logic [11:0] ra(input int p, input int k);
        return 12'(p * 32 + k * 4);
    endfunction : ra

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, read data and error are all taken at the completing rising edge.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Register effects reach the pins one edge after the write; three are allowed.
    task automatic settle;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Looks for an interrupt pulse on the pin 3 line for a few cycles.
    task automatic look;
        seen = 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (irq[1] === 1'b1) seen = 1'b1;
        end
    endtask : look

    // Sets one pin as a row says, then compares pad drive and peripheral input.
    task automatic run_row(input logic [18:0] r);
        int                        p;
        int                        b;
        logic [15:0]               m;
        pmx_pkg::alt_drive_s [6:0] v;
        p = int'(r[18:16]);
        b = int'(r[15:12]);
        m = 16'h0001 << b;
        v = '0;
        v[p] = {r[6] ? m : 16'h0000, r[5] ? m : 16'h0000, r[4] ? m : 16'h0000,
            r[3] ? m : 16'h0000};
        @(posedge clk);
        alt <= v;
        apb(1'b1, ra(p, 0), {16'h0000, r[7] ? m : 16'h0000});
        apb(1'b1, ra(p, 1), {16'h0000, r[9] ? 16'hFFFF : ~m});
        apb(1'b1, ra(p, 2), {16'h0000, r[11] ? m : 16'h0000});
        apb(1'b1, ra(p, 3), {16'h0000, r[10] ? m : 16'h0000});
        apb(1'b1, ra(p, 4), {16'h0000, r[8] ? m : 16'h0000});
        settle;
        chk("pin_o", 32'(r[2]), 32'(drv[p].o[b]));
        chk("pin_oe", 32'(r[1]), 32'(drv[p].oe[b]));
        chk("alt_in", 32'(r[0]), 32'(alt_in[p][b]));
    endtask : run_row

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Cuts a hang short; the whole run needs far fewer cycles.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    // Main sequence: reset, table rows, then key return, edges and a bad address.
    initial begin
        rows = '{
            {3'h3, 4'h0, 12'h086}, {3'h3, 4'h1, 12'hA67},
            {3'h2, 4'h3, 12'hE4A}, {3'h2, 4'h3, 12'hA19},
            {3'h4, 4'h2, 12'hE3F}, {3'h2, 4'h8, 12'hB61},
            {3'h2, 4'h8, 12'hB22}, {3'h3, 4'h1, 12'hB67},
            {3'h4, 4'h4, 12'hB67}, {3'h4, 4'h4, 12'hF19},
            {3'h5, 4'hD, 12'hE1F}, {3'h5, 4'h0, 12'hE3A},
            {3'h1, 4'h0, 12'hAE4}, {3'h6, 4'h0, 12'hA67},
            {3'h6, 4'h0, 12'h002}, {3'h3, 4'h2, 12'h102}};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, ra(pmx_pkg::IX_P0, 1), '0);
        chk("dir_reset", 32'h0000_FFFF, rd);
        apb(1'b0, ra(pmx_pkg::IX_P3, 2), '0);
        chk("mode_reset", 32'h0000_0000, rd);
        chk("oe_reset", 32'h0000_0000, 32'(drv[3].oe));
        for (int i = 0; i < 16; i++) begin
            run_row(rows[i]);
        end
        apb(1'b1, ra(pmx_pkg::IX_P5, 2), '0);
        apb(1'b1, ra(pmx_pkg::IX_P5, 3), '0);
        apb(1'b1, ra(pmx_pkg::IX_P5, 1), 32'h0000_FFFF);
        apb(1'b1, ra(pmx_pkg::IX_P5, 4), 32'h0000_0010);
        apb(1'b1, 12'h100, 32'h0000_003F);
        settle;
        chk("key_ret", 32'h0000_002F, 32'(kr));
        apb(1'b0, 12'h10C, '0);
        chk("kr_status", 32'h0000_002F, rd);
        apb(1'b1, ra(pmx_pkg::IX_P5, 1), 32'h0000_FFFE);
        ext[4][1] <= 1'b0;
        settle;
        chk("key_ret_dir", 32'h0000_002C, 32'(kr));
        apb(1'b1, ra(pmx_pkg::IX_P0, 2), 32'h0000_0008);
        apb(1'b1, 12'h104, 32'h0000_0008);
        apb(1'b1, 12'h108, 32'h0000_0000);
        ext[0][3] <= 1'b0;
        settle;
        @(posedge clk);
        ext[0][3] <= 1'b1;
        look();
        chk("irq_rise", 32'h0000_0001, 32'(seen));
        @(posedge clk);
        ext[0][3] <= 1'b0;
        look();
        chk("irq_fall", 32'h0000_0000, 32'(seen));
        apb(1'b0, 12'h200, '0);
        chk("bad_err", 32'h0000_0001, 32'(err));
        chk("bad_data", 32'h0000_0000, rd);
        print_verdict();
    end
endmodule : port_alt_mux_tb
